//--- verilog/thermal_mode_pkg.sv
package thermal_mode_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS        = 10;
  localparam int unsigned RESET_PULSE_MIN_NS   = 18000;
  localparam int unsigned RESET_PULSE_MAX_NS   = 35000;
  localparam int unsigned SLEEP_ENTRY_NS       = 50000;
  localparam int unsigned WAKE_NS              = 1000;
  // least time rounds up, longest rounds down
  localparam int unsigned RESET_PULSE_MIN_CYC  =
    (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_PULSE_MAX_CYC  = RESET_PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_ENTRY_CYC      =
    (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYC             =
    (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W                = 16;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic RECOVERY_SELECT_RST = 1'b0;
  localparam logic FLAG_RST            = 1'b0;

  typedef enum logic [1:0] {
    ST_ACTIVE   = 2'b00,
    ST_SLEEPING = 2'b01,
    ST_ASLEEP   = 2'b10,
    ST_WAKING   = 2'b11
  } power_state_e;

endpackage

//--- verilog/sync_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sync_bus_if;
  logic [4:0] raw;
  logic [4:0] synced;
  modport producer (output raw, input synced);
  modport syncer   (input raw, output synced);
endinterface
`default_nettype wire

//--- verilog/input_sync.sv
`timescale 1ns/10ps
`default_nettype none
module input_sync (
  input  wire logic    clk,
  input  wire logic    rst,
  sync_bus_if.syncer   bus
);
  typedef struct packed {
    logic [4:0] meta;
    logic [4:0] stable;
  } sync_s;

  sync_s state_r;
  sync_s state_nxt;

  // first stage is read only by the second stage
  always_comb begin
    state_nxt        = state_r;
    state_nxt.meta   = bus.raw;
    state_nxt.stable = state_r.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // start at the pins' present levels so no false edge follows reset
      state_r <= {bus.raw, bus.raw};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign bus.synced = state_r.stable;
endmodule
`default_nettype wire

//--- verilog/thermal_mode_ctrl.sv
// Notes on behaviour
// - shutdown disables bridge, pump; latches flags
// - shutdown protection cannot be disabled
// - mode 0 keeps outputs off until cleared
// - mode 1 recovers when shutdown condition ends
// - after recovery, shutdown flags stay until cleared
// - overtemp warning sets flags, operation continues
// - overtemp warning flags clear themselves
// - report bit routes overtemp warning to fault
// - undertemp warning sets flags, operation continues
// - undertemp warning flags clear themselves
// - report bit routes undertemp warning to fault
// - sleep disables bridge, regulator, pump, serial
// - sleep entered only after entry delay
// - wake on sleep pin high; host waits
// - drive-off pin forces outputs high impedance
// - disable bit ORed with drive-off pin
// - active only awake, drive enabled, supply good
// - short sleep pulse clears latched faults
`timescale 1ns/10ps
`default_nettype none
module thermal_mode_ctrl (
  input  wire logic CLK_SYS,
  input  wire logic RESET,
  input  wire logic SLEEP_N_PIN,
  input  wire logic DRIVE_OFF_PIN,
  input  wire logic THERMAL_SHUTDOWN,
  input  wire logic OVERTEMP_WARNING,
  input  wire logic UNDERTEMP_WARNING,
  input  wire logic SUPPLY_UNDERVOLTAGE_LOCKOUT,
  input  wire logic OUTPUT_DISABLE_BIT,
  input  wire logic THERMAL_RECOVERY_SELECT,
  input  wire logic TEMP_WARNING_REPORT,
  input  wire logic CLEAR_FAULTS_CMD,
  output logic      FAULT_N_PIN_O,
  output logic      FAULT_N_PIN_OE,
  output logic      SUMMARY_FAULT,
  output logic      TEMPERATURE_FLAG,
  output logic      OVERTEMP_SHUTDOWN_FLAG,
  output logic      OVERTEMP_WARNING_FLAG,
  output logic      UNDERTEMP_WARNING_FLAG,
  output logic      BRIDGE_ENABLE,
  output logic      CHARGE_PUMP_ENABLE,
  output logic      REGULATOR_ENABLE,
  output logic      SERIAL_ENABLE,
  output logic      READY_FOR_INPUTS
);
  import thermal_mode_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    power_state_e     pstate;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] wake_cnt;
    logic             sleep_prev;
    logic             shutdown_hold;
    logic             shutdown_flag;
    logic             fault;
    logic             temp_flag;
    logic             otw_flag;
    logic             utw_flag;
    logic             bridge_en;
    logic             pump_en;
    logic             awake;
    logic             ready;
  } ctrl_s;

  ctrl_s state_r;
  ctrl_s state_nxt;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  sync_bus_if sync_bus ();

  assign sync_bus.raw = {SLEEP_N_PIN, DRIVE_OFF_PIN, THERMAL_SHUTDOWN,
                         OVERTEMP_WARNING, UNDERTEMP_WARNING};

  input_sync u_sync (
    .clk (CLK_SYS),
    .rst (RESET),
    .bus (sync_bus.syncer)
  );

  logic sleep_n_s;
  logic drive_off_s;
  logic tsd_s;
  logic otw_s;
  logic utw_s;
  assign {sleep_n_s, drive_off_s, tsd_s, otw_s, utw_s} = sync_bus.synced;

  // ****************************************************************
  // next state
  // ****************************************************************
  logic pulse_clear;
  logic clear_any;
  logic warn_fault;
  logic drive_block;

  always_comb begin
    state_nxt = state_r;
    state_nxt.sleep_prev = sleep_n_s;

    pulse_clear = 1'b0;
    if (!sleep_n_s) begin
      if (state_r.low_cnt != {CNT_W{1'b1}}) begin
        state_nxt.low_cnt = state_r.low_cnt + 1'b1;
      end
    end else begin
      state_nxt.low_cnt = '0;
      // no upper bound: long pulses past entry delay clear here as well as in the asleep state below
      if (!state_r.sleep_prev && state_r.low_cnt > CNT_W'(RESET_PULSE_MIN_CYC)) begin
        pulse_clear = 1'b1;
      end
    end
    clear_any = CLEAR_FAULTS_CMD | pulse_clear;

    case (state_r.pstate)
      ST_ACTIVE: begin
        if (!sleep_n_s) begin
          state_nxt.pstate = ST_SLEEPING;
        end
      end
      ST_SLEEPING: begin
        if (sleep_n_s) begin
          state_nxt.pstate = ST_ACTIVE;
        end else if (state_r.low_cnt >= CNT_W'(SLEEP_ENTRY_CYC)) begin
          state_nxt.pstate = ST_ASLEEP;
        end
      end
      ST_ASLEEP: begin
        if (sleep_n_s) begin
          state_nxt.pstate   = ST_WAKING;
          state_nxt.wake_cnt = '0;
        end
      end
      ST_WAKING: begin
        if (!sleep_n_s) begin
          state_nxt.pstate = ST_SLEEPING;
        end else if (state_r.wake_cnt >= CNT_W'(WAKE_CYC - 1)) begin
          state_nxt.pstate = ST_ACTIVE;
        end else begin
          state_nxt.wake_cnt = state_r.wake_cnt + 1'b1;
        end
      end
      default: begin
        state_nxt.pstate = ST_ACTIVE;
      end
    endcase
    state_nxt.awake = (state_nxt.pstate != ST_ASLEEP);
    state_nxt.ready = (state_nxt.pstate == ST_ACTIVE);

    if (state_r.pstate == ST_ASLEEP) begin
      state_nxt.shutdown_hold = FLAG_RST;
      state_nxt.shutdown_flag = FLAG_RST;
    end else begin
      if (tsd_s) begin
        state_nxt.shutdown_hold = 1'b1;
        state_nxt.shutdown_flag = 1'b1;
      end else begin
        if (clear_any) begin
          state_nxt.shutdown_flag = 1'b0;
          state_nxt.shutdown_hold = 1'b0;
        end
        if (THERMAL_RECOVERY_SELECT) begin
          state_nxt.shutdown_hold = 1'b0;
        end
      end
    end

    state_nxt.otw_flag  = otw_s && state_r.pstate != ST_ASLEEP;
    state_nxt.utw_flag  = utw_s && state_r.pstate != ST_ASLEEP;
    state_nxt.temp_flag = state_nxt.otw_flag | state_nxt.utw_flag |
                          state_nxt.shutdown_flag;

    warn_fault = TEMP_WARNING_REPORT & (state_nxt.otw_flag | state_nxt.utw_flag);
    state_nxt.fault = state_nxt.shutdown_hold | warn_fault;

    drive_block = drive_off_s | OUTPUT_DISABLE_BIT;
    state_nxt.bridge_en = state_nxt.ready & ~drive_block &
                          ~SUPPLY_UNDERVOLTAGE_LOCKOUT & ~state_nxt.shutdown_hold;
    state_nxt.pump_en = state_nxt.awake & ~SUPPLY_UNDERVOLTAGE_LOCKOUT &
                        ~state_nxt.shutdown_hold;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_r            <= '0;
      state_r.pstate     <= ST_ACTIVE;
      state_r.sleep_prev <= 1'b1;
      state_r.awake      <= 1'b1;
      state_r.ready      <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // open drain: low is driven, high released
  assign FAULT_N_PIN_O          = 1'b0;
  assign FAULT_N_PIN_OE         = state_r.fault;
  assign SUMMARY_FAULT          = state_r.fault;
  assign TEMPERATURE_FLAG       = state_r.temp_flag;
  assign OVERTEMP_SHUTDOWN_FLAG = state_r.shutdown_flag;
  assign OVERTEMP_WARNING_FLAG  = state_r.otw_flag;
  assign UNDERTEMP_WARNING_FLAG = state_r.utw_flag;
  assign BRIDGE_ENABLE          = state_r.bridge_en;
  assign CHARGE_PUMP_ENABLE     = state_r.pump_en;
  assign REGULATOR_ENABLE       = state_r.awake;
  assign SERIAL_ENABLE          = state_r.awake;
  assign READY_FOR_INPUTS       = state_r.ready;
endmodule
`default_nettype wire

//--- tb/thermal_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module thermal_asserts (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic SLEEP_N_PIN,
  input wire logic DRIVE_OFF_PIN,
  input wire logic THERMAL_SHUTDOWN,
  input wire logic OVERTEMP_WARNING,
  input wire logic OUTPUT_DISABLE_BIT,
  input wire logic TEMP_WARNING_REPORT,
  input wire logic CLEAR_FAULTS_CMD,
  input wire logic FAULT_N_PIN_OE,
  input wire logic SUMMARY_FAULT,
  input wire logic OVERTEMP_SHUTDOWN_FLAG,
  input wire logic OVERTEMP_WARNING_FLAG,
  input wire logic BRIDGE_ENABLE,
  input wire logic CHARGE_PUMP_ENABLE
);
  // ********
  // checks
  // ********
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);
  // pins cross two flops, so three samples precede the effect
  sequence hot_s;
    THERMAL_SHUTDOWN [*3];
  endsequence
  sequence cool_clear_s;
    !THERMAL_SHUTDOWN [*3] ##0 CLEAR_FAULTS_CMD;
  endsequence
  shut_latch_a:
    assert property (hot_s |=> OVERTEMP_SHUTDOWN_FLAG && SUMMARY_FAULT && FAULT_N_PIN_OE)
    else $error("shutdown not latched");
  shut_off_a:
    assert property (hot_s |=> !BRIDGE_ENABLE && !CHARGE_PUMP_ENABLE)
    else $error("shutdown left drive on");
  flag_hold_a:
    assert property ((SLEEP_N_PIN [*4] ##0 (OVERTEMP_SHUTDOWN_FLAG && !CLEAR_FAULTS_CMD))
      |=> OVERTEMP_SHUTDOWN_FLAG) else $error("shutdown flag lost");
  clear_cool_a:
    assert property (cool_clear_s |=> !OVERTEMP_SHUTDOWN_FLAG) else $error("clear ignored");
  warn_set_a:
    assert property (OVERTEMP_WARNING [*3] |=> OVERTEMP_WARNING_FLAG) else $error("warn unset");
  warn_clear_a:
    assert property (!OVERTEMP_WARNING [*3] |=> !OVERTEMP_WARNING_FLAG) else $error("warn stuck");
  warn_report_a:
    assert property ((OVERTEMP_WARNING && TEMP_WARNING_REPORT) [*4] |=> SUMMARY_FAULT
      && FAULT_N_PIN_OE) else $error("warn not reported");
  drive_off_a:
    assert property ((DRIVE_OFF_PIN [*3]) or OUTPUT_DISABLE_BIT |=> !BRIDGE_ENABLE)
    else $error("bridge not off");
endmodule
bind thermal_mode_ctrl thermal_asserts i_chk (.*);
`default_nettype wire

//--- tb/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic clk,
  output var logic  sleep_n
);
  // ********
  // sleep pin driver
  // ********
  initial sleep_n = 1'h1;
  // hold then wait
  // the caller picks the span: a short low clears, a long low sleeps
  task automatic drive(logic v, int unsigned cyc);
    sleep_n = v;
    repeat (cyc) @(negedge clk);
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import thermal_mode_pkg::*;
  logic CLK_SYS, RESET, SLEEP_N_PIN, DRIVE_OFF_PIN, THERMAL_SHUTDOWN, OVERTEMP_WARNING;
  logic UNDERTEMP_WARNING, SUPPLY_UNDERVOLTAGE_LOCKOUT, OUTPUT_DISABLE_BIT, CLEAR_FAULTS_CMD;
  logic THERMAL_RECOVERY_SELECT, TEMP_WARNING_REPORT, FAULT_N_PIN_O, FAULT_N_PIN_OE;
  logic SUMMARY_FAULT, TEMPERATURE_FLAG, OVERTEMP_SHUTDOWN_FLAG, OVERTEMP_WARNING_FLAG;
  logic UNDERTEMP_WARNING_FLAG, BRIDGE_ENABLE, CHARGE_PUMP_ENABLE, REGULATOR_ENABLE;
  logic SERIAL_ENABLE, READY_FOR_INPUTS;
  int   miscompares = 0;
  int   samples_checked = 0;
  thermal_mode_ctrl i_dut (.*);
  host_model i_host (.clk(CLK_SYS), .sleep_n(SLEEP_N_PIN));
  // ********
  // stimulus
  // ********
  always #(CLK_PERIOD_NS / 2) CLK_SYS = ~CLK_SYS;
  task automatic step(int n);
    repeat (n) @(negedge CLK_SYS);
  endtask
  task automatic chk(string nm, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic clear_pulse();
    CLEAR_FAULTS_CMD = 1'h1;
    step(1);
    CLEAR_FAULTS_CMD = 1'h0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    CLK_SYS = 1'h0;
    RESET = 1'h1;
    {DRIVE_OFF_PIN, THERMAL_SHUTDOWN, OVERTEMP_WARNING, UNDERTEMP_WARNING} = 4'h0;
    {SUPPLY_UNDERVOLTAGE_LOCKOUT, OUTPUT_DISABLE_BIT, CLEAR_FAULTS_CMD} = 3'h0;
    {THERMAL_RECOVERY_SELECT, TEMP_WARNING_REPORT} = 2'h0;
    step(20);
    RESET = 1'h0;
    step(5);
    chk("bridge", 1'h1, BRIDGE_ENABLE);
    DRIVE_OFF_PIN = 1'h1;
    step(4);
    chk("bridge", 1'h0, BRIDGE_ENABLE);
    DRIVE_OFF_PIN = 1'h0;
    OUTPUT_DISABLE_BIT = 1'h1;
    step(4);
    chk("bridge", 1'h0, BRIDGE_ENABLE);
    OUTPUT_DISABLE_BIT = 1'h0;
    step(2);
    chk("bridge", 1'h1, BRIDGE_ENABLE);
    $display("gating test done");
    THERMAL_SHUTDOWN = 1'h1;
    step(4);
    chk("shut flag", 1'h1, OVERTEMP_SHUTDOWN_FLAG);
    chk("pump", 1'h0, CHARGE_PUMP_ENABLE);
    chk("bridge", 1'h0, BRIDGE_ENABLE);
    chk("summary", 1'h1, SUMMARY_FAULT);
    chk("fault pin", 1'h1, FAULT_N_PIN_OE);
    chk("fault level", 1'h0, FAULT_N_PIN_O);
    chk("temp flag", 1'h1, TEMPERATURE_FLAG);
    clear_pulse();
    chk("shut flag", 1'h1, OVERTEMP_SHUTDOWN_FLAG);
    THERMAL_SHUTDOWN = 1'h0;
    step(8);
    chk("bridge", 1'h0, BRIDGE_ENABLE);
    clear_pulse();
    chk("shut flag", 1'h0, OVERTEMP_SHUTDOWN_FLAG);
    chk("bridge", 1'h1, BRIDGE_ENABLE);
    THERMAL_RECOVERY_SELECT = 1'h1;
    THERMAL_SHUTDOWN = 1'h1;
    step(4);
    THERMAL_SHUTDOWN = 1'h0;
    step(4);
    chk("bridge", 1'h1, BRIDGE_ENABLE);
    chk("summary", 1'h0, SUMMARY_FAULT);
    chk("temp flag", 1'h1, TEMPERATURE_FLAG);
    i_host.drive(1'h0, (RESET_PULSE_MIN_CYC + RESET_PULSE_MAX_CYC) / 2);
    i_host.drive(1'h1, WAKE_CYC + 4);
    chk("shut flag", 1'h0, OVERTEMP_SHUTDOWN_FLAG);
    chk("pump", 1'h1, CHARGE_PUMP_ENABLE);
    $display("shutdown test done");
    for (int i = 0; i < 4; i++) begin
      TEMP_WARNING_REPORT = i[1];
      OVERTEMP_WARNING = !i[0];
      UNDERTEMP_WARNING = i[0];
      step(4);
      chk("warn", 1'h1, i[0] ? UNDERTEMP_WARNING_FLAG : OVERTEMP_WARNING_FLAG);
      chk("fault pin", i[1], FAULT_N_PIN_OE);
      chk("bridge", 1'h1, BRIDGE_ENABLE);
      {OVERTEMP_WARNING, UNDERTEMP_WARNING} = 2'h0;
      step(4);
      chk("temp flag", 1'h0, TEMPERATURE_FLAG);
    end
    $display("warning test done");
    i_host.drive(1'h0, SLEEP_ENTRY_CYC - 100);
    chk("regulator", 1'h1, REGULATOR_ENABLE);
    i_host.drive(1'h0, 110);
    chk("regulator", 1'h0, REGULATOR_ENABLE);
    chk("serial", 1'h0, SERIAL_ENABLE);
    i_host.drive(1'h1, 10);
    chk("ready", 1'h0, READY_FOR_INPUTS);
    i_host.drive(1'h1, WAKE_CYC);
    chk("ready", 1'h1, READY_FOR_INPUTS);
    SUPPLY_UNDERVOLTAGE_LOCKOUT = 1'h1;
    step(2);
    chk("bridge", 1'h0, BRIDGE_ENABLE);
    $display("sleep test done");
    give_verdict();
  end
  // a run that outlives three sleep spans has hung
  initial begin
    repeat (3 * SLEEP_ENTRY_CYC) @(posedge CLK_SYS);
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
